// ==== logic/plmc_cell.sv ====
// One macrocell with its I/O control cell and a Wishbone configuration port
//
// Behaviour
// - Five local product terms feed each cell before any expander.
// - Each local term goes to the OR path or to preset, clock or enable.
// - Shareable and parallel expanders extend the sum up to 32 terms.
// - Register acts as D, T, JK or SR flip-flop.
// - Combinational mode bypasses the flip-flop.
// - Clock modes: global, global with high enable, or array clock.
// - Array clock comes from a product term of buried or pin signals.
// - Two global clocks, each true or inverted from one of two pins.
// - Preset and clear are active-high product terms.
// - Clear optionally follows the low global clear pin.
// - Power-up level loads cfg[PLMC_CFG_PWRUP] right after reset, while cfg still holds zero.
// - Without programmable power-up the register starts low.
// - Fast pin path feeds the register data input directly.
// - Tri-state control at zero makes the pin an input only.
// - Tri-state control at one keeps the driver enabled.
// - Output enable picks one of six or ten global enables.
// - Pin feedback and macrocell feedback are independent.
// - Cells are organised in groups of sixteen.
`timescale 1ns/1ps
`default_nettype none
module plmc_cell
  import plmc_pkg::*;
#(
  parameter int TERMS = PLMC_MAX_TERMS,
  parameter int NUM_OE = PLMC_OE_SMALL,
  parameter int GROUP_CELLS = PLMC_GROUP_CELLS,
  parameter int CELL_INDEX = 0,
  parameter bit PWRUP_PROG = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Device pins
  input wire logic global_clock_pin_a_i,
  input wire logic global_clock_pin_b_i,
  input wire logic global_clear_pin_low_i,
  input wire logic io_pin_i,
  output logic io_pin_o,
  output logic io_pin_oe_o,
  // Array side
  input wire logic [PLMC_LOCAL_TERMS-1:0] local_terms_i,
  input wire logic [TERMS-PLMC_LOCAL_TERMS-1:0] exp_terms_i,
  input wire logic [NUM_OE-1:0] global_oe_i,
  input wire logic clear_term_i,
  output logic cell_feedback_o,
  output logic pin_feedback_o,
  output logic shared_exp_o
);
  import plmc_pkg::*;

  initial begin
    if (NUM_OE != PLMC_OE_SMALL && NUM_OE != PLMC_OE_LARGE) begin
      $error("plmc_cell: NUM_OE must be six or ten");
    end
    if (GROUP_CELLS != PLMC_GROUP_CELLS || CELL_INDEX < 0) begin
      $error("plmc_cell: group must hold sixteen cells");
    end
  end

  localparam int GROUP_INDEX = CELL_INDEX / GROUP_CELLS;

  logic [31:0] cfg;
  logic [TERMS-PLMC_LOCAL_TERMS-1:0] exp_en;
  logic [2*PLMC_LOCAL_TERMS-1:0] pt_route;
  logic reg_q;
  logic pwrup_done;
  logic [2:0] gin_s;
  logic [1:0] pin_s;
  logic gclk_a;
  logic gclk_b;
  logic gclr_low;
  logic pin_sync;
  logic pin_ext;
  logic sum;
  logic logic_out;
  logic data_in;
  logic preset;
  logic clk_term;
  logic clken_term;
  logic clear;
  logic sel_clk;
  logic sel_clk_d;
  logic clk_edge;
  logic clk_fire;
  logic next_q;
  logic next_oe;
  logic wb_hit;
  logic wb_wr;
  logic [31:0] exp_en_merge;
  logic [31:0] route_merge;

  plmc_ff_t ff_type;
  plmc_clk_t clk_mode;
  plmc_oe_t oe_mode;

  // Destination of local term i
  function automatic plmc_pt_t pt_dest(input logic [2*PLMC_LOCAL_TERMS-1:0] r, input int i);
    return plmc_pt_t'(r[2*i +: 2]);
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Clear pin enters inverted so the synchroniser's reset value reads as idle
  plmc_sync #(.WIDTH(3)) u_gsync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({~global_clear_pin_low_i, global_clock_pin_b_i, global_clock_pin_a_i}),
    .sync_o(gin_s)
  );

  plmc_sync #(.WIDTH(1)) u_psync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(io_pin_i),
    .sync_o(pin_sync)
  );

  assign gclk_a = gin_s[0];
  assign gclk_b = gin_s[1];
  assign gclr_low = ~gin_s[2];
  assign pin_ext = pin_sync;
  assign ff_type = plmc_ff_t'(cfg[PLMC_CFG_FFTYPE +: 2]);
  assign clk_mode = plmc_clk_t'(cfg[PLMC_CFG_CLKMODE +: 2]);
  assign oe_mode = plmc_oe_t'(cfg[PLMC_CFG_OEMODE +: 2]);
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Writes land at the edge where the master sees ack
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign exp_en_merge = lane_merge(32'(exp_en), wb_dat_i, wb_sel_i);
  assign route_merge = lane_merge(32'(pt_route), wb_dat_i, wb_sel_i);

  // Split local terms by destination
  logic [PLMC_LOCAL_TERMS-1:0] to_or;
  always_comb begin
    to_or = '0;
    preset = 1'b0;
    clk_term = 1'b0;
    clken_term = 1'b0;
    for (int i = 0; i < PLMC_LOCAL_TERMS; i++) begin
      unique case (pt_dest(pt_route, i))
        PLMC_PT_OR: to_or[i] = 1'b1;
        PLMC_PT_PRESET: preset = preset | local_terms_i[i];
        PLMC_PT_CLOCK: clk_term = clk_term | local_terms_i[i];
        PLMC_PT_CLKEN: clken_term = clken_term | local_terms_i[i];
      endcase
    end
  end

  plmc_terms #(.TERMS(TERMS)) u_terms (
    .local_i(local_terms_i),
    .to_or_i(to_or),
    .exp_i(exp_terms_i),
    .exp_en_i(exp_en),
    .sum_o(sum)
  );

  assign logic_out = sum ^ cfg[PLMC_CFG_XOR];
  assign data_in = cfg[PLMC_CFG_FASTIN] ? pin_ext : logic_out;
  assign clear = clear_term_i | (cfg[PLMC_CFG_GCLR_EN] & ~gclr_low);

  // Clock selection
  always_comb begin
    sel_clk = (cfg[PLMC_CFG_GSEL] ? gclk_b : gclk_a) ^ cfg[PLMC_CFG_GINV];
    clk_fire = 1'b0;
    unique case (clk_mode)
      PLMC_CLK_GLOBAL: clk_fire = clk_edge;
      PLMC_CLK_GLOBAL_EN: clk_fire = clk_edge & clken_term;
      PLMC_CLK_ARRAY: clk_fire = clk_edge;
      default: clk_fire = 1'b0;
    endcase
  end

  logic edge_src;
  assign edge_src = (clk_mode == PLMC_CLK_ARRAY) ? clk_term : sel_clk;
  assign clk_edge = edge_src & ~sel_clk_d;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_clk_d <= 1'b0;
    end else begin
      sel_clk_d <= edge_src;
    end
  end

  // Flip-flop emulation
  always_comb begin
    next_q = reg_q;
    unique case (ff_type)
      PLMC_FF_D: next_q = data_in;
      PLMC_FF_T: next_q = reg_q ^ data_in;
      PLMC_FF_JK: next_q = (data_in & ~reg_q) | (~local_terms_i[0] & reg_q);
      PLMC_FF_SR: next_q = data_in | (reg_q & ~local_terms_i[0]);
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_q <= PLMC_RESET_LOW;
      pwrup_done <= 1'b0;
    end else if (!pwrup_done) begin
      reg_q <= PWRUP_PROG ? cfg[PLMC_CFG_PWRUP] : PLMC_RESET_LOW;
      pwrup_done <= 1'b1;
    end else if (clear) begin
      reg_q <= 1'b0;
    end else if (preset) begin
      reg_q <= 1'b1;
    end else if (clk_fire) begin
      reg_q <= next_q;
    end
  end

  // Output enable
  always_comb begin
    unique case (oe_mode)
      PLMC_OE_OFF: next_oe = 1'b0;
      PLMC_OE_ON: next_oe = 1'b1;
      PLMC_OE_GLOBAL: next_oe = global_oe_i[cfg[PLMC_CFG_OESEL +: 4] % NUM_OE];
      default: next_oe = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      io_pin_o <= 1'b0;
      io_pin_oe_o <= 1'b0;
      cell_feedback_o <= 1'b0;
      pin_feedback_o <= 1'b0;
      shared_exp_o <= 1'b0;
    end else begin
      io_pin_o <= cfg[PLMC_CFG_BYPASS] ? logic_out : reg_q;
      io_pin_oe_o <= next_oe;
      cell_feedback_o <= cfg[PLMC_CFG_BYPASS] ? logic_out : reg_q;
      pin_feedback_o <= pin_ext;
      shared_exp_o <= ~(&local_terms_i);
    end
  end

  // Wishbone register file
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg <= PLMC_CFG_RESET;
      exp_en <= '0;
      pt_route <= '0;
    end else if (wb_wr) begin
      unique case (wb_adr_i)
        PLMC_REG_CFG: cfg <= lane_merge(cfg, wb_dat_i, wb_sel_i);
        PLMC_REG_TERM: exp_en <= exp_en_merge[TERMS-PLMC_LOCAL_TERMS-1:0];
        PLMC_REG_PTROUTE: pt_route <= route_merge[2*PLMC_LOCAL_TERMS-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        unique case (wb_adr_i)
          PLMC_REG_CFG: wb_dat_o <= cfg;
          PLMC_REG_TERM: wb_dat_o <= 32'(exp_en);
          PLMC_REG_PTROUTE: wb_dat_o <= 32'(pt_route);
          PLMC_REG_STATUS: wb_dat_o <= {24'h0, 4'(GROUP_INDEX), pin_ext, io_pin_oe_o, sum,
                                        reg_q};
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  // Clear beats preset within one cycle
  clear_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwrup_done && clear) |=> !reg_q)
    else $error("register not low after clear");

  preset_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwrup_done && preset && !clear) |=> reg_q)
    else $error("register not high after preset");

  oe_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (oe_mode == PLMC_OE_OFF) |=> !io_pin_oe_o)
    else $error("driver enabled while tied off");

  oe_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (oe_mode == PLMC_OE_ON) |=> io_pin_oe_o)
    else $error("driver disabled while tied on");

  bypass_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg[PLMC_CFG_BYPASS] |=> (io_pin_o == $past(logic_out)))
    else $error("bypass output wrong");

  hold_no_clk_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwrup_done && !clear && !preset && !clk_fire) |=> $stable(reg_q))
    else $error("register moved without clock");

  dff_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwrup_done && !clear && !preset && clk_fire && ff_type == PLMC_FF_D)
    |=> (reg_q == $past(data_in)))
    else $error("D load wrong");

  gclr_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwrup_done && cfg[PLMC_CFG_GCLR_EN] && !gclr_low) |=> !reg_q)
    else $error("global clear ignored");

  wb_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_hit |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not single cycle");

  pwrup_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !pwrup_done |=> (reg_q == (PWRUP_PROG ? $past(cfg[PLMC_CFG_PWRUP]) : 1'b0)))
    else $error("power-up level wrong");

  fast_in_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwrup_done && !clear && !preset && clk_fire && ff_type == PLMC_FF_D &&
     cfg[PLMC_CFG_FASTIN]) |=> (reg_q == $past(pin_ext)))
    else $error("fast input not loaded");
endmodule
`default_nettype wire

// ==== logic/plmc_pkg.sv ====
// Package: constants and types for the macrocell model
package plmc_pkg;
  localparam int PLMC_LOCAL_TERMS = 5;
  localparam int PLMC_MAX_TERMS = 32;
  localparam int PLMC_GROUP_CELLS = 16;
  localparam int PLMC_OE_SMALL = 6;
  localparam int PLMC_OE_LARGE = 10;
  localparam int PLMC_NUM_GCLK = 2;
  localparam int PLMC_SYNC_STAGES = 3;
  localparam logic PLMC_RESET_LOW = 1'h0;

  // Wishbone register offsets
  localparam logic [7:0] PLMC_REG_CFG = 8'h00;
  localparam logic [7:0] PLMC_REG_TERM = 8'h04;
  localparam logic [7:0] PLMC_REG_PTROUTE = 8'h08;
  localparam logic [7:0] PLMC_REG_STATUS = 8'h0c;

  // Config register field positions
  localparam int PLMC_CFG_FFTYPE = 0;
  localparam int PLMC_CFG_BYPASS = 2;
  localparam int PLMC_CFG_CLKMODE = 3;
  localparam int PLMC_CFG_GSEL = 5;
  localparam int PLMC_CFG_GINV = 6;
  localparam int PLMC_CFG_GCLR_EN = 7;
  localparam int PLMC_CFG_PWRUP = 8;
  localparam int PLMC_CFG_FASTIN = 9;
  localparam int PLMC_CFG_OEMODE = 10;
  localparam int PLMC_CFG_OESEL = 12;
  localparam int PLMC_CFG_XOR = 16;
  localparam logic [31:0] PLMC_CFG_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {PLMC_FF_D, PLMC_FF_T, PLMC_FF_JK, PLMC_FF_SR} plmc_ff_t;
  typedef enum logic [1:0] {PLMC_CLK_GLOBAL, PLMC_CLK_GLOBAL_EN, PLMC_CLK_ARRAY, PLMC_CLK_RSVD}
    plmc_clk_t;
  typedef enum logic [1:0] {PLMC_OE_OFF, PLMC_OE_ON, PLMC_OE_GLOBAL, PLMC_OE_RSVD} plmc_oe_t;
  // Product term destinations
  typedef enum logic [1:0] {PLMC_PT_OR, PLMC_PT_PRESET, PLMC_PT_CLOCK, PLMC_PT_CLKEN}
    plmc_pt_t;
endpackage

// ==== logic/plmc_sync.sv ====
// Three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/1ps
`default_nettype none
module plmc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_o <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2[i] == s3[i]) begin
          sync_o[i] <= s3[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== logic/plmc_terms.sv ====
// Product-term sum with shareable and parallel expanders
`timescale 1ns/1ps
`default_nettype none
module plmc_terms
  import plmc_pkg::*;
#(
  parameter int TERMS = PLMC_MAX_TERMS
) (
  // Local terms routed to the OR path
  input wire logic [PLMC_LOCAL_TERMS-1:0] local_i,
  input wire logic [PLMC_LOCAL_TERMS-1:0] to_or_i,
  // Expander terms and their enables
  input wire logic [TERMS-PLMC_LOCAL_TERMS-1:0] exp_i,
  input wire logic [TERMS-PLMC_LOCAL_TERMS-1:0] exp_en_i,
  // Sum
  output logic sum_o
);
  initial begin
    if (TERMS < PLMC_LOCAL_TERMS + 1 || TERMS > PLMC_MAX_TERMS) begin
      $error("plmc_terms: TERMS out of range");
    end
  end

  always_comb begin
    sum_o = (|(local_i & to_or_i)) | (|(exp_i & exp_en_i));
  end
endmodule
`default_nettype wire

// ==== tb/plmc_tb.sv ====
// Self-checking testbench for one macrocell with its I/O control cell
`timescale 1ns/1ps
`default_nettype none
module tb;
  import plmc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic pa = 1'b0;
  logic pb = 1'b0;
  logic gclr_low = 1'b1;
  logic pin = 1'b0;
  logic pin_o;
  logic oe_o;
  logic [4:0] terms = 5'h00;
  logic [26:0] ex_terms = 27'h0;
  logic [5:0] goe = 6'h00;
  logic clr = 1'b0;
  logic fb;
  logic pfb;
  logic sx;
  int errors = 0;
  int samples_checked = 0;

  always #5 clk_i = ~clk_i;

  plmc_cell dut (
    .clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .global_clock_pin_a_i(pa), .global_clock_pin_b_i(pb),
    .global_clear_pin_low_i(gclr_low), .io_pin_i(pin), .io_pin_o(pin_o),
    .io_pin_oe_o(oe_o), .local_terms_i(terms), .exp_terms_i(ex_terms),
    .global_oe_i(goe), .clear_term_i(clr), .cell_feedback_o(fb),
    .pin_feedback_o(pfb), .shared_exp_o(sx)
  );

  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] ex);
    samples_checked++;
    if (seen !== ex) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, ex, seen);
    end
  endtask

  // Classic single cycle; the request holds until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] r);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20) begin
      errors++;
      $display("MISMATCH bus_ack expected 1 seen none");
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, 4'hf, r);
  endtask

  task automatic rd_check(input string name, input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, 4'hf, r);
    check(name, r, ex);
  endtask

  task automatic setup(input logic [31:0] cfg, input logic [31:0] route, input logic [31:0] en);
    wr(PLMC_REG_CFG, cfg);
    wr(PLMC_REG_PTROUTE, route);
    wr(PLMC_REG_TERM, en);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Register state as seen in the status register
  task automatic reg_is(input logic ex);
    logic [31:0] r;
    wait_n(6);
    wb(1'b0, PLMC_REG_STATUS, 32'h0, 4'hf, r);
    check("reg_state", r[0], ex);
  endtask

  task automatic clk_pin(input bit b, input logic v);
    if (b) begin
      pb <= v;
    end else begin
      pa <= v;
    end
    wait_n(8);
  endtask

  task automatic pulse(input bit b);
    clk_pin(b, 1'b1);
    clk_pin(b, 1'b0);
  endtask

  task automatic t_regs();
    logic [31:0] r;
    rd_check("status_reset", PLMC_REG_STATUS, 32'h0);
    rd_check("cfg_reset", PLMC_REG_CFG, PLMC_CFG_RESET);
    wb(1'b1, PLMC_REG_CFG, 32'h0000_31ff, 4'h1, r);
    rd_check("cfg_lane", PLMC_REG_CFG, 32'h0000_00ff);
    wr(PLMC_REG_CFG, 32'h0001_2345);
    rd_check("cfg_rw", PLMC_REG_CFG, 32'h0001_2345);
    wr(PLMC_REG_TERM, 32'hffff_ffff);
    rd_check("exp_enables", PLMC_REG_TERM, 32'h07ff_ffff);
    wr(PLMC_REG_PTROUTE, 32'h0000_03ff);
    rd_check("term_route", PLMC_REG_PTROUTE, 32'h0000_03ff);
    wr(8'h10, 32'hffff_ffff);
    rd_check("unmapped", 8'h10, 32'h0);
  endtask

  task automatic t_comb();
    setup(32'h4, 32'h0, 32'h0);
    for (int i = 0; i < PLMC_LOCAL_TERMS; i++) begin
      terms <= 5'(1 << i);
      wait_n(6);
      check("bypass_term", fb, 1'b1);
      check("bypass_pin", pin_o, 1'b1);
    end
    terms <= 5'h1f;
    wait_n(6);
    check("shared_exp_all", sx, 1'b0);
    terms <= 5'h00;
    wait_n(6);
    check("bypass_zero", fb, 1'b0);
    check("shared_exp_none", sx, 1'b1);
    wr(PLMC_REG_PTROUTE, 32'h100);
    terms <= 5'h10;
    wait_n(6);
    check("term_to_preset", fb, 1'b0);
    terms <= 5'h00;
    wr(PLMC_REG_CFG, 32'h0001_0004);
    wait_n(6);
    check("xor_invert", fb, 1'b1);
    setup(32'h4, 32'h0, 32'h0400_0000);
    ex_terms <= 27'h400_0000;
    wait_n(6);
    check("expander_on", fb, 1'b1);
    wr(PLMC_REG_TERM, 32'h0);
    wait_n(6);
    check("expander_off", fb, 1'b0);
    ex_terms <= 27'h0;
  endtask

  task automatic t_clocks();
    setup(32'h0, 32'h0, 32'h0);
    terms <= 5'h00;
    pulse(1'b0);
    reg_is(1'b0);
    terms <= 5'h01;
    pulse(1'b0);
    reg_is(1'b1);
    pb <= 1'b1;
    terms <= 5'h00;
    wait_n(6);
    setup(32'h60, 32'h0, 32'h0);
    pulse(1'b0);
    reg_is(1'b1);
    clk_pin(1'b1, 1'b0);
    reg_is(1'b0);
    setup(32'h8, 32'hc, 32'h0);
    terms <= 5'h01;
    pulse(1'b0);
    reg_is(1'b0);
    terms <= 5'h03;
    pulse(1'b0);
    reg_is(1'b1);
    terms <= 5'h00;
    setup(32'h10, 32'h20, 32'h0);
    terms <= 5'h04;
    reg_is(1'b0);
    terms <= 5'h01;
    reg_is(1'b0);
    terms <= 5'h05;
    reg_is(1'b1);
    terms <= 5'h00;
  endtask

  task automatic t_types();
    logic [4:0] jk [4] = '{5'h02, 5'h01, 5'h03, 5'h00};
    logic jk_ex [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    setup(32'h1, 32'h0, 32'h0);
    terms <= 5'h01;
    pulse(1'b0);
    reg_is(1'b0);
    pulse(1'b0);
    reg_is(1'b1);
    setup(32'h2, 32'h3, 32'h0);
    for (int i = 0; i < 4; i++) begin
      terms <= jk[i];
      pulse(1'b0);
      reg_is(jk_ex[i]);
    end
    setup(32'h3, 32'h3, 32'h0);
    for (int i = 1; i < 4; i++) begin
      terms <= jk[i];
      pulse(1'b0);
      reg_is(i != 1);
    end
  endtask

  task automatic t_async();
    setup(32'h0, 32'h0, 32'h0);
    clr <= 1'b1;
    reg_is(1'b0);
    clr <= 1'b0;
    wr(PLMC_REG_PTROUTE, 32'h100);
    terms <= 5'h10;
    reg_is(1'b1);
    clr <= 1'b1;
    reg_is(1'b0);
    clr <= 1'b0;
    reg_is(1'b1);
    gclr_low <= 1'b0;
    reg_is(1'b1);
    wr(PLMC_REG_CFG, 32'h80);
    reg_is(1'b0);
    gclr_low <= 1'b1;
    terms <= 5'h00;
    reg_is(1'b0);
  endtask

  task automatic t_io();
    setup(32'h200, 32'h0, 32'h0);
    pin <= 1'b1;
    wait_n(8);
    check("pin_feedback", pfb, 1'b1);
    pulse(1'b0);
    reg_is(1'b1);
    check("cell_feedback", fb, 1'b1);
    check("pin_data", pin_o, 1'b1);
    pin <= 1'b0;
    pulse(1'b0);
    reg_is(1'b0);
    check("oe_off", oe_o, 1'b0);
    wr(PLMC_REG_CFG, 32'h400);
    wait_n(4);
    check("oe_on", oe_o, 1'b1);
    for (int k = 0; k < PLMC_OE_SMALL; k++) begin
      wr(PLMC_REG_CFG, 32'h800 | (k << PLMC_CFG_OESEL));
      goe <= 6'(1 << k);
      wait_n(4);
      check("oe_global_hi", oe_o, 1'b1);
      goe <= ~6'(1 << k);
      wait_n(4);
      check("oe_global_lo", oe_o, 1'b0);
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    wrap_up();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_comb();
    t_clocks();
    t_types();
    t_async();
    t_io();
    wrap_up();
  end
endmodule
`default_nettype wire
